// ### inc/ordet_defs.svh
// Offsets, field positions, reset values and timing counts of the orientation detector.
// Included by bare name; holds definitions only.
// ==========================================================================
`ifndef ORDET_DEFS_SVH
`define ORDET_DEFS_SVH
// Register indexes; byte address is four times the index
`define ORDET_IDX_STATUS 6'h10
`define ORDET_IDX_CONFIG 6'h11
`define ORDET_IDX_DEBOUNCE 6'h12
`define ORDET_IDX_FACE_TILT 6'h13
`define ORDET_RST_CONFIG 8'h80
`define ORDET_RST_DEBOUNCE 8'h00
`define ORDET_RST_FACE_TILT 8'h84
`define ORDET_BIT_CHANGED 7
`define ORDET_BIT_DECAY 7
`define ORDET_BIT_ENABLE 6
`define ORDET_FACE_MSB 7
`define ORDET_FACE_LSB 6
`define ORDET_ZLOCK_MSB 2
`define ORDET_LAPO_PU 2'h0
`define ORDET_LAPO_PD 2'h1
`define ORDET_LAPO_LR 2'h2
`define ORDET_LAPO_LL 2'h3
// Oversampling mode codes on i_osmode
`define ORDET_OS_NORMAL 2'h0
`define ORDET_OS_QUIET 2'h1
`define ORDET_OS_HIRES 2'h2
`define ORDET_OS_LOWPWR 2'h3
// Accel scale is 4096 counts per g; hold limit is 1.25 g
`define ORDET_HOLD_LIMIT 14'h1400
`define ORDET_STEP_NS 1250000
`define ORDET_CLK_NS 40
`endif

// ### inc/ordet_pkg.sv
// Types shared by the orientation detector modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ordet_pkg;
  typedef enum logic [1:0] {ORDET_IDLE, ORDET_FIRST, ORDET_TRACK} ordet_state_e;
  typedef struct packed {
    logic tilt;
    logic [1:0] lapo;
    logic face;
  } ordet_orient_s;
  typedef logic signed [13:0] ordet_accel_t;
endpackage : ordet_pkg

// ### inc/ordet_cand_if.sv
// Carries one sample and thresholds to the classifier, and its candidate back.
// Assumes the classifier is purely combinational.
`timescale 1ns/1ps
interface ordet_cand_if;
  import ordet_pkg::*;
  ordet_accel_t x;
  ordet_accel_t y;
  ordet_accel_t z;
  logic [2:0] zlock;
  logic [1:0] face_thr;
  logic cur_face;
  ordet_orient_s cand;
  logic hold;
  modport src (output x, y, z, zlock, face_thr, cur_face, input cand, hold);
  modport cls (input x, y, z, zlock, face_thr, cur_face, output cand, hold);
endinterface : ordet_cand_if

// ### hw/ordet_classify.sv
// Turns one accelerometer sample into a candidate orientation.
// Assumes 4096 counts per g and a caller that registers the result.
`timescale 1ns/1ps
`include "ordet_defs.svh"
module ordet_classify
  import ordet_pkg::*;
(
  ordet_cand_if.cls cif
);
  function automatic logic [13:0] mag(input ordet_accel_t v);
    return v[13] ? 14'(-v) : 14'(v);
  endfunction : mag

  // Lateral limit is g times sine of the lockout angle
  function automatic logic [13:0] zlock_lim(input logic [2:0] code);
    unique case (code)
      3'h0: return 14'h0401;
      3'h1: return 14'h04FF;
      3'h2: return 14'h05FE;
      3'h3: return 14'h06FD;
      3'h4: return 14'h0800;
      3'h5: return 14'h08FE;
      3'h6: return 14'h0A00;
      3'h7: return 14'h0AFE;
    endcase
  endfunction : zlock_lim

  // Z limit is g times cosine of 80, 75, 70 or 65 degrees
  function automatic logic [13:0] face_lim(input logic [1:0] code);
    unique case (code)
      2'h0: return 14'h02C7;
      2'h1: return 14'h0424;
      2'h2: return 14'h0579;
      2'h3: return 14'h06C3;
    endcase
  endfunction : face_lim

  logic [13:0] ax;
  logic [13:0] ay;
  logic [13:0] az;
  logic signed [14:0] flim;

  always_comb
  begin
    ax = mag(cif.x);
    ay = mag(cif.y);
    az = mag(cif.z);
    flim = $signed({1'b0, face_lim(cif.face_thr)});
    cif.hold = (ax > `ORDET_HOLD_LIMIT) || (ay > `ORDET_HOLD_LIMIT)
      || (az > `ORDET_HOLD_LIMIT);
    if (ay >= ax)
      cif.cand.lapo = cif.y[13] ? `ORDET_LAPO_PU : `ORDET_LAPO_PD;
    else
      cif.cand.lapo = cif.x[13] ? `ORDET_LAPO_LL : `ORDET_LAPO_LR;
    // Lockout when the device lies too flat to tell its rotation
    cif.cand.tilt = (ax < zlock_lim(cif.zlock)) && (ay < zlock_lim(cif.zlock));
    // Between the two trip angles the face keeps its last value
    if ($signed({cif.z[13], cif.z}) > flim)
      cif.cand.face = 1'b0;
    else if ($signed({cif.z[13], cif.z}) < -flim)
      cif.cand.face = 1'b1;
    else
      cif.cand.face = cif.cur_face;
  end
endmodule : ordet_classify

// ### hw/ordet_step_timer.sv
// Makes one debounce step pulse per effective sample period.
// Assumes i_restart pulses when the data rate or power state changes.
`timescale 1ns/1ps
`include "ordet_defs.svh"
module ordet_step_timer #(
  parameter int unsigned STEP_CYCLES = `ORDET_STEP_NS / `ORDET_CLK_NS
)(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_hybrid,
  input wire logic [2:0] i_odr,
  input wire logic [1:0] i_osmode,
  output logic o_step
);
  localparam int CW = $clog2(STEP_CYCLES + 1);

  // Step length in 1.25 ms units; each mode saturates differently
  function automatic logic [8:0] step_units(input logic [2:0] odr, input logic [1:0] m);
    logic [8:0] u;
    // Rates below 50 Hz are not a power of two apart; the slowest is capped
    // at 128 units because every mode saturates at or below that
    if (odr == 3'h5)
      u = 9'h040;
    else if (odr > 3'h5)
      u = 9'h080;
    else
      u = 9'h001 << odr;
    unique case (m)
      `ORDET_OS_NORMAL: if (u > 9'h010) u = 9'h010;
      `ORDET_OS_QUIET: if (u > 9'h040) u = 9'h040;
      `ORDET_OS_HIRES: if (u > 9'h002) u = 9'h002;
      `ORDET_OS_LOWPWR: if (u > 9'h080) u = 9'h080;
    endcase
    return u;
  endfunction : step_units

  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic [9:0] units;
  logic [9:0] next_units;
  logic [9:0] limit;
  logic next_step;

  always_comb
  begin
    limit = {1'b0, step_units(i_odr, i_osmode)};
    if (i_hybrid)
      limit = {limit[8:0], 1'b0};
    next_cyc = cyc + CW'(1);
    next_units = units;
    next_step = 1'b0;
    if (i_restart)
    begin
      next_cyc = '0;
      next_units = '0;
    end
    else if (cyc == CW'(STEP_CYCLES - 1))
    begin
      next_cyc = '0;
      next_units = units + 10'h001;
      if (units + 10'h001 >= limit)
      begin
        next_units = '0;
        next_step = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cyc <= '0;
      units <= '0;
      o_step <= 1'b0;
    end
    else
    begin
      cyc <= next_cyc;
      units <= next_units;
      o_step <= next_step;
    end
  end
endmodule : ordet_step_timer

// ### hw/ordet_top.sv
// Orientation detector with its register file on an Avalon-MM slave.
// Assumes samples, data rate and power state arrive synchronous to i_clock.
`timescale 1ns/1ps
`include "ordet_defs.svh"
module ordet_top
  import ordet_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `ORDET_STEP_NS / `ORDET_CLK_NS
)(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_active,
  input wire logic i_hybrid,
  input wire logic [2:0] i_odr,
  input wire logic [1:0] i_osmode,
  input wire logic i_sample_valid,
  input wire logic [13:0] i_accel_x,
  input wire logic [13:0] i_accel_y,
  input wire logic [13:0] i_accel_z,
  output logic o_orient_changed
);
  // ==========================================================================
  // Register bus
  logic [7:0] orientation_config;
  logic [7:0] orientation_debounce;
  logic [7:0] face_tilt_threshold;
  logic [7:0] next_config;
  logic [7:0] next_debounce;
  logic [7:0] next_face_tilt;
  logic [31:0] next_readdata;
  logic next_waitreq;
  logic [5:0] word;
  logic req;
  logic cap;
  logic done;
  logic stat_rd;
  logic [7:0] rd_mux;
  ordet_orient_s cur;
  logic flag;

  assign word = i_avs_address[7:2];
  assign req = i_avs_read | i_avs_write;
  // Reads are captured while waitrequest is high so the clear hits the value seen
  assign cap = req & o_avs_waitrequest;
  assign done = req & ~o_avs_waitrequest;
  assign stat_rd = cap & i_avs_read & (word == `ORDET_IDX_STATUS);

  always_comb
  begin
    unique case (word)
      `ORDET_IDX_STATUS: rd_mux = {flag, cur.tilt, 3'h0, cur.lapo, cur.face};
      `ORDET_IDX_CONFIG: rd_mux = {orientation_config[7:6], 6'h00};
      `ORDET_IDX_DEBOUNCE: rd_mux = orientation_debounce;
      `ORDET_IDX_FACE_TILT: rd_mux = {face_tilt_threshold[7:6], 3'h0,
        face_tilt_threshold[2:0]};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_waitreq = ~cap;
    next_readdata = o_avs_readdata;
    next_config = orientation_config;
    next_debounce = orientation_debounce;
    next_face_tilt = face_tilt_threshold;
    if (cap && i_avs_read)
      next_readdata = {24'h000000, rd_mux};
    if (done && i_avs_write && i_avs_byteenable[0])
    begin
      unique case (word)
        `ORDET_IDX_CONFIG: next_config = {i_avs_writedata[7:6], 6'h00};
        `ORDET_IDX_DEBOUNCE: next_debounce = i_avs_writedata[7:0];
        `ORDET_IDX_FACE_TILT: next_face_tilt = {i_avs_writedata[7:6], 3'h0,
          i_avs_writedata[2:0]};
        default: next_debounce = orientation_debounce;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      orientation_config <= `ORDET_RST_CONFIG;
      orientation_debounce <= `ORDET_RST_DEBOUNCE;
      face_tilt_threshold <= `ORDET_RST_FACE_TILT;
    end
    else
    begin
      o_avs_waitrequest <= next_waitreq;
      o_avs_readdata <= next_readdata;
      orientation_config <= next_config;
      orientation_debounce <= next_debounce;
      face_tilt_threshold <= next_face_tilt;
    end
  end

  // ==========================================================================
  // Sample path and classifier
  ordet_cand_if cif();
  ordet_accel_t smp_x;
  ordet_accel_t smp_y;
  ordet_accel_t smp_z;
  logic step;
  logic restart;
  logic run;
  logic decay;
  logic [2:0] odr_q;
  logic active_q;

  assign cif.x = smp_x;
  assign cif.y = smp_y;
  assign cif.z = smp_z;
  assign cif.zlock = face_tilt_threshold[`ORDET_ZLOCK_MSB:0];
  assign cif.face_thr = face_tilt_threshold[`ORDET_FACE_MSB:`ORDET_FACE_LSB];
  assign cif.cur_face = cur.face;
  assign run = orientation_config[`ORDET_BIT_ENABLE] & i_active;
  assign decay = orientation_config[`ORDET_BIT_DECAY];
  assign restart = (i_odr != odr_q) | (i_active != active_q);

  ordet_classify u_classify (
    .cif(cif.cls)
  );

  ordet_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_restart(restart),
    .i_hybrid(i_hybrid),
    .i_odr(i_odr),
    .i_osmode(i_osmode),
    .o_step(step)
  );

  // ==========================================================================
  // Debounce and commit
  ordet_state_e state;
  ordet_state_e next_state;
  ordet_orient_s next_cur;
  ordet_orient_s prev;
  ordet_orient_s next_prev;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [8:0] cnt_inc;
  logic next_flag;
  logic have;
  logic next_have;
  logic commit;
  ordet_accel_t next_x;
  ordet_accel_t next_y;
  ordet_accel_t next_z;

  assign cnt_inc = {1'b0, cnt} + 9'h001;

  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_prev = prev;
    next_cnt = cnt;
    next_flag = flag;
    next_have = have | i_sample_valid;
    next_x = smp_x;
    next_y = smp_y;
    next_z = smp_z;
    commit = 1'b0;
    if (i_sample_valid)
    begin
      next_x = i_accel_x;
      next_y = i_accel_y;
      next_z = i_accel_z;
    end
    if (stat_rd)
      next_flag = 1'b0;
    if (restart)
      next_cnt = 8'h00;
    unique case (state)
      ORDET_IDLE:
      begin
        next_have = i_sample_valid;
        if (run)
          next_state = ORDET_FIRST;
      end
      ORDET_FIRST:
        if (step && have && !cif.hold)
        begin
          next_cur = cif.cand;
          next_prev = cif.cand;
          next_flag = 1'b1;
          commit = 1'b1;
          next_state = ORDET_TRACK;
        end
      ORDET_TRACK:
        if (step && !cif.hold && !restart)
        begin
          next_prev = cif.cand;
          if (cif.cand != cur && cif.cand == prev)
          begin
            if (cnt_inc >= {1'b0, orientation_debounce})
            begin
              // Fields follow the sample even if the host has not read yet
              next_cur = cif.cand;
              next_cnt = 8'h00;
              next_flag = 1'b1;
              commit = 1'b1;
            end
            else
              next_cnt = cnt_inc[7:0];
          end
          else if (decay)
            next_cnt = 8'h00;
          else if (cnt != 8'h00)
            next_cnt = cnt - 8'h01;
        end
    endcase
    if (!run)
      next_state = ORDET_IDLE;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ORDET_IDLE;
      cur <= '0;
      prev <= '0;
      cnt <= 8'h00;
      flag <= 1'b0;
      have <= 1'b0;
      smp_x <= '0;
      smp_y <= '0;
      smp_z <= '0;
      odr_q <= 3'h0;
      active_q <= 1'b0;
      o_orient_changed <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      prev <= next_prev;
      cnt <= next_cnt;
      flag <= next_flag;
      have <= next_have;
      smp_x <= next_x;
      smp_y <= next_y;
      smp_z <= next_z;
      odr_q <= i_odr;
      active_q <= i_active;
      o_orient_changed <= next_flag;
    end
  end

  // ==========================================================================
  // Checks
  default clocking ast_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_CHANGE_FLAG: assert property (
    commit |=> flag && o_orient_changed)
    else $error("change flag not set after commit");
  AST_READ_CLEAR: assert property (
    (stat_rd && !commit) |=> !flag ##0 !o_orient_changed)
    else $error("status read did not clear change flag");
  AST_BIT7: assert property (
    stat_rd |=> !o_avs_waitrequest && o_avs_readdata[7] == $past(flag))
    else $error("bit 7 does not show change flag");
  AST_TRACK_SET: assert property (
    (commit && flag) |=> cur == $past(cif.cand))
    else $error("fields frozen while change flag set");
  AST_HOLD: assert property (
    (cif.hold && state == ORDET_TRACK) |=> cur == $past(cur))
    else $error("orientation changed above hold limit");
  AST_DISABLED: assert property (
    !orientation_config[`ORDET_BIT_ENABLE] |=> state == ORDET_IDLE ##1 !commit)
    else $error("detection ran while disabled");
  AST_DECAY_CLEAR: assert property (
    (state == ORDET_TRACK && step && !cif.hold && decay && cif.cand == cur)
      |=> cnt == 8'h00)
    else $error("counter not cleared in clear mode");
  AST_RESTART: assert property (
    restart |=> cnt == 8'h00)
    else $error("debounce counter not reset on rate or power change");
  AST_COMMIT_COUNT: assert property (
    (state == ORDET_TRACK && commit) |-> cnt_inc >= {1'b0, orientation_debounce})
    else $error("commit before debounce count reached");
  AST_BUS_ANSWER: assert property (
    cap |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");

  AST_WAIT_IDLE: assert property (
    !req |=> o_avs_waitrequest)
    else $error("waitrequest low with no request");
  AST_RD_STABLE: assert property (
    !cap |=> o_avs_readdata == $past(o_avs_readdata))
    else $error("read data moved without a read");
  AST_RESERVED_ZERO: assert property (
    stat_rd |=> o_avs_readdata[31:8] == 24'h000000 && o_avs_readdata[5:3] == 3'h0)
    else $error("reserved status bits not zero");
  AST_WRITE_LAND: assert property (
    (done && i_avs_write && i_avs_byteenable[0] && word == `ORDET_IDX_DEBOUNCE)
      |=> orientation_debounce == $past(i_avs_writedata[7:0]))
    else $error("debounce write did not land");
  AST_BE_IGNORE: assert property (
    (done && i_avs_write && !i_avs_byteenable[0])
      |=> orientation_config == $past(orientation_config)
      && orientation_debounce == $past(orientation_debounce)
      && face_tilt_threshold == $past(face_tilt_threshold))
    else $error("write with low byte disabled changed a register");

  // Fixed-limit checks: these samples classify the same way at every threshold code
  AST_HOLD_LIMIT: assert property (
    (smp_x > 14'sh1400) |-> cif.hold)
    else $error("sample above hold limit not held");
  AST_FACE_FRONT: assert property (
    (smp_z > 14'sh06C3) |-> !cif.cand.face)
    else $error("face not front for a steep positive z");
  AST_FACE_BACK: assert property (
    (smp_z < -14'sh06C3) |-> cif.cand.face)
    else $error("face not back for a steep negative z");
  AST_LAPO_PU: assert property (
    (smp_x == 14'sh0000 && smp_y < 14'sh0000) |-> cif.cand.lapo == `ORDET_LAPO_PU)
    else $error("negative y alone not classed portrait up");
  AST_LAPO_LR: assert property (
    (smp_y == 14'sh0000 && smp_x > 14'sh0000) |-> cif.cand.lapo == `ORDET_LAPO_LR)
    else $error("positive x alone not classed landscape right");
  AST_TILT_FLAT: assert property (
    (smp_x == 14'sh0000 && smp_y == 14'sh0000) |-> cif.cand.tilt)
    else $error("flat device not locked out");
  AST_FIRST_COMMIT: assert property (
    (state == ORDET_FIRST && run && step && have && !cif.hold)
      |=> state == ORDET_TRACK && flag)
    else $error("first result after activation not flagged");
  AST_STANDBY_IDLE: assert property (
    !i_active |=> state == ORDET_IDLE)
    else $error("detection ran in standby");

  COV_FIRST: cover property (state == ORDET_FIRST ##[1:1000] commit);
  COV_READ_SET: cover property (stat_rd && commit);
  COV_HOLD: cover property (cif.hold && step && state == ORDET_TRACK);
  COV_DEBOUNCE: cover property (commit && orientation_debounce > 8'h02);
  COV_STANDBY: cover property (!i_active ##1 i_active);
endmodule : ordet_top

// ### testbench/ordet_host_model.sv
// Host model: an Avalon-MM master that reads and writes the detector registers.
// Assumes a slave that answers by dropping waitrequest for one cycle.
`timescale 1ns/1ps
module ordet_host_model (
  input wire logic i_clock,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [7:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  // ==========================================================================
  // Idle bus
  initial
  begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h00000000;
    o_byteenable = 4'h0;
  end

  // ==========================================================================
  // One transfer
  // The request stays put until waitrequest is seen low at a rising edge,
  // so a slow answer never shortens the transfer.
  task automatic xfer(input logic rd, input logic [5:0] idx, input logic [7:0] wd,
                      input logic [3:0] be, output logic [7:0] rdat);
    @(posedge i_clock);
    o_address <= {idx, 2'b00};
    o_read <= rd;
    o_write <= ~rd;
    o_writedata <= {24'h000000, wd};
    o_byteenable <= be;
    do
      @(posedge i_clock);
    while (i_waitrequest !== 1'b0);
    rdat = i_readdata[7:0];
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask : xfer
endmodule : ordet_host_model

// ### testbench/tb_top.sv
// Self-checking bench for the orientation detector: registers, codes and timing.
// Assumes the host model drives the bus and a debounce unit of 4 clock cycles.
`timescale 1ns/1ps
`include "ordet_defs.svh"
module tb_top;
  localparam int unsigned STEP = 4;
  localparam logic [13:0] P1G = 14'h1000;
  localparam logic [13:0] N1G = 14'h3000;
  localparam logic [13:0] ZF = 14'h07D0;
  localparam logic [13:0] ZB = 14'h3830;
  localparam logic [13:0] BIG = 14'h1770;
  localparam logic [13:0] NUL = 14'h0000;
  logic clock;
  logic rst_n;
  logic [7:0] address;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] be;
  logic waitreq;
  logic active;
  logic hybrid;
  logic [2:0] odr;
  logic [1:0] osmode;
  logic svalid;
  logic [13:0] ax;
  logic [13:0] ay;
  logic [13:0] az;
  logic changed;
  int mismatches;
  int checked;
  logic [7:0] d;
  logic [13:0] tx [5];
  logic [13:0] ty [5];
  logic [13:0] tz [5];
  logic [7:0] te [5];

  ordet_top #(.STEP_CYCLES(STEP)) i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_avs_address(address), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_active(active),
    .i_hybrid(hybrid), .i_odr(odr), .i_osmode(osmode), .i_sample_valid(svalid),
    .i_accel_x(ax), .i_accel_y(ay), .i_accel_z(az), .o_orient_changed(changed)
  );
  ordet_host_model i_host (
    .i_clock(clock), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(address),
    .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be)
  );

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_reg(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] exp);
    i_host.xfer(1'b1, idx, 8'h00, 4'hF, d);
    chk(d & mask, exp);
  endtask : rd_reg
  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] val, input logic [3:0] en);
    i_host.xfer(1'b0, idx, val, en, d);
  endtask : wr_reg
  task automatic flag(input logic e);
    chk({7'h00, changed}, {7'h00, e});
  endtask : flag
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
    @(posedge clock);
    ax <= x;
    ay <= y;
    az <= z;
    svalid <= 1'b1;
    @(posedge clock);
    svalid <= 1'b0;
  endtask : smp
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitc
  task automatic end_sim;
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #(40 * 4000);
    mismatches++;
    end_sim;
  end

  // ==========================================================================
  // Tests
  initial
  begin
    rst_n = 1'b0;
    active = 1'b1;
    hybrid = 1'b0;
    odr = 3'h0;
    osmode = 2'h0;
    svalid = 1'b0;
    ax = NUL;
    ay = NUL;
    az = NUL;
    mismatches = 0;
    checked = 0;
    tx = '{NUL, NUL, P1G, N1G, N1G};
    ty = '{N1G, P1G, NUL, NUL, NUL};
    tz = '{ZF, ZF, ZF, ZF, ZB};
    te = '{8'h80, 8'h82, 8'h84, 8'h86, 8'h87};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    flag(1'b0);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h00);
    rd_reg(`ORDET_IDX_CONFIG, 8'hFF, 8'h80);
    rd_reg(`ORDET_IDX_DEBOUNCE, 8'hFF, 8'h00);
    rd_reg(`ORDET_IDX_FACE_TILT, 8'hFF, 8'h84);
    wr_reg(`ORDET_IDX_FACE_TILT, 8'hFF, 4'hF);
    rd_reg(`ORDET_IDX_FACE_TILT, 8'hFF, 8'hC7);
    wr_reg(`ORDET_IDX_FACE_TILT, 8'h84, 4'hF);
    wr_reg(`ORDET_IDX_DEBOUNCE, 8'h55, 4'h0);
    rd_reg(`ORDET_IDX_DEBOUNCE, 8'hFF, 8'h00);
    rd_reg(6'h14, 8'hFF, 8'h00);
    wr_reg(`ORDET_IDX_CONFIG, 8'hFF, 4'hF);
    rd_reg(`ORDET_IDX_CONFIG, 8'hFF, 8'hC0);
    for (int i = 0; i < 5; i++)
    begin
      smp(tx[i], ty[i], tz[i]);
      waitc(40);
      flag(1'b1);
      rd_reg(`ORDET_IDX_STATUS, 8'hFF, te[i]);
      rd_reg(`ORDET_IDX_STATUS, 8'hFF, te[i] & 8'h7F);
      flag(1'b0);
    end
    // Two changes with no read between: fields must follow the second one
    smp(NUL, N1G, ZF);
    waitc(40);
    smp(NUL, P1G, ZF);
    waitc(40);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h82);
    smp(NUL, NUL, P1G);
    waitc(40);
    rd_reg(`ORDET_IDX_STATUS, 8'hC1, 8'hC0);
    smp(BIG, NUL, ZF);
    waitc(40);
    flag(1'b0);
    rd_reg(`ORDET_IDX_STATUS, 8'hC1, 8'h40);
    wr_reg(`ORDET_IDX_CONFIG, 8'h80, 4'hF);
    smp(P1G, NUL, ZF);
    waitc(40);
    flag(1'b0);
    wr_reg(`ORDET_IDX_CONFIG, 8'hC0, 4'hF);
    // Samples seen while idle are dropped, so a fresh one starts detection
    smp(P1G, NUL, ZF);
    waitc(40);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h84);
    @(posedge clock);
    active <= 1'b0;
    waitc(10);
    active <= 1'b1;
    smp(P1G, NUL, ZF);
    waitc(40);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h84);
    wr_reg(`ORDET_IDX_DEBOUNCE, 8'h04, 4'hF);
    smp(N1G, NUL, ZF);
    waitc(10);
    flag(1'b0);
    waitc(40);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h86);
    @(posedge clock);
    hybrid <= 1'b1;
    smp(P1G, NUL, ZF);
    waitc(20);
    flag(1'b0);
    waitc(60);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h84);
    @(posedge clock);
    hybrid <= 1'b0;
    odr <= 3'h3;
    osmode <= `ORDET_OS_HIRES;
    wr_reg(`ORDET_IDX_DEBOUNCE, 8'h01, 4'hF);
    smp(NUL, N1G, ZF);
    waitc(20);
    flag(1'b1);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h80);
    @(posedge clock);
    odr <= 3'h5;
    osmode <= `ORDET_OS_QUIET;
    smp(NUL, P1G, ZF);
    waitc(400);
    flag(1'b0);
    waitc(200);
    flag(1'b1);
    rd_reg(`ORDET_IDX_STATUS, 8'hFF, 8'h82);
    @(posedge clock);
    odr <= 3'h6;
    osmode <= `ORDET_OS_LOWPWR;
    smp(NUL, N1G, ZF);
    waitc(900);
    flag(1'b0);
    waitc(200);
    flag(1'b1);
    end_sim;
  end
endmodule : tb_top
